// file: rtl/bus_arbiter_pkg.sv
// constants for the secondary bus request arbiter
package bus_arbiter_pkg;
    localparam int          NUM_REQ         = 9;
    localparam logic [7:0]  CFG_OFFSET      = 8'h48;
    localparam int          ENABLE_LSB      = 0;
    localparam int          STRAP_BIT       = 9;
    localparam int          TIMEOUT_EN_BIT  = 10;
    localparam int          REFRESH_EN_BIT  = 11;
    localparam int          FAIR_LSB        = 12;
    localparam int          FAIR_MSB        = 19;
    localparam int          TOGGLE_EN_BIT   = 20;
    localparam int          PRIO_LSB        = 22;
    localparam logic [8:0]  ENABLE_RESET    = 9'h1ff;
    localparam logic [7:0]  FAIR_RESET      = 8'h08;
    localparam logic [8:0]  PRIO_RESET      = 9'h001;
    localparam logic [31:0] WRITE_MASK      = 32'h7fdffdff;
    localparam logic [4:0]  BROKEN_CYCLES   = 5'h10;
    localparam logic [1:0]  TOGGLE_DELAY    = 2'h2;
endpackage

// file: rtl/bus_request_arbiter.sv
// arbiter granting the secondary bus among internal and eight external masters
`timescale 1ns/1ps
`default_nettype none
module bus_request_arbiter
    import bus_arbiter_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic [8:0]        req_n_i,
    input  wire logic              frame_n_i,
    input  wire logic              irdy_n_i,
    input  wire logic              arbiter_select_strap_i,
    input  wire logic              cfg_wr_i,
    input  wire logic [7:0]        cfg_addr_i,
    input  wire logic [31:0]       cfg_wdata_i,
    output logic      [31:0]       cfg_rdata_o,
    output logic      [8:0]        gnt_n_o,
    output logic      [8:0]        broken_o
);
    typedef enum logic [1:0] {IDLE, WAIT_FRAME, OWNED} arb_state_t;

    // pin inputs pass two flops; only the second stage is used
    logic [8:0] req_s1, req_s2;
    logic       frame_s1, frame_s2, irdy_s1, irdy_s2, strap_s1, strap_s2;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            req_s1   <= 9'h1ff;
            req_s2   <= 9'h1ff;
            frame_s1 <= 1'b1;
            frame_s2 <= 1'b1;
            irdy_s1  <= 1'b1;
            irdy_s2  <= 1'b1;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            req_s1   <= req_n_i;
            req_s2   <= req_s1;
            frame_s1 <= frame_n_i;
            frame_s2 <= frame_s1;
            irdy_s1  <= irdy_n_i;
            irdy_s2  <= irdy_s1;
            strap_s1 <= arbiter_select_strap_i;
            strap_s2 <= strap_s1;
        end
    end

    logic [8:0] enable, prio, broken, served, gnt_n;
    logic       timeout_en, refresh_en, toggle_en, ext_arb;
    logic [7:0] fair_field, fair_cnt;
    logic [4:0] idle_cnt;
    logic [1:0] tog_cnt;
    logic       fair_armed, frame_prev, tog_done;
    logic [3:0] owner;
    arb_state_t state;

    logic [8:0] next_enable, next_prio, next_broken, next_served, next_gnt_n;
    logic       next_timeout_en, next_refresh_en, next_toggle_en;
    logic       next_ext_arb, next_fair_armed, next_tog_done;
    logic [7:0] next_fair_field, next_fair_cnt;
    logic [4:0] next_idle_cnt;
    logic [1:0] next_tog_cnt;
    logic [3:0] next_owner;
    arb_state_t next_state;
    logic [31:0] reg_word, next_rdata;

    logic [8:0] req, eligible;
    logic       bus_idle, frame_fall, others_wait, cfg_hit;
    logic [3:0] pick;
    logic       pick_ok;

    assign req        = ~req_s2;
    assign bus_idle   = frame_s2 && irdy_s2;
    assign frame_fall = frame_prev && !frame_s2;
    assign cfg_hit    = cfg_wr_i && (cfg_addr_i == CFG_OFFSET);
    assign eligible   = req & enable & ~broken;

    // high-priority group first, then lowest index; a simple fixed scan
    always_comb begin
        pick    = 4'h0;
        pick_ok = 1'b0;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (eligible[i] && !prio[i] && !pick_ok) pick = 4'(i);
        end
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (eligible[i] && prio[i]) pick = 4'(i);
        end
        pick_ok = |eligible;
    end

    always_comb begin
        others_wait = 1'b0;
        for (int i = 0; i < NUM_REQ; i++) begin
            if (eligible[i] && owner != 4'(i)) others_wait = 1'b1;
        end
    end

    always_comb begin
        reg_word = '0;
        reg_word[ENABLE_LSB +: NUM_REQ] = enable;
        reg_word[STRAP_BIT]             = ext_arb;
        reg_word[TIMEOUT_EN_BIT]        = timeout_en;
        reg_word[REFRESH_EN_BIT]        = refresh_en;
        reg_word[FAIR_MSB:FAIR_LSB]     = fair_field;
        reg_word[TOGGLE_EN_BIT]         = toggle_en;
        reg_word[PRIO_LSB +: NUM_REQ]   = prio;
        next_rdata = (cfg_addr_i == CFG_OFFSET) ? reg_word : 32'h0000_0000;
    end

    // configuration writes; the strap bit and reserved bits are read only
    always_comb begin
        next_enable     = enable;
        next_prio       = prio;
        next_timeout_en = timeout_en;
        next_refresh_en = refresh_en;
        next_fair_field = fair_field;
        next_toggle_en  = toggle_en;
        next_ext_arb    = strap_s2;
        if (cfg_hit) begin
            next_enable     = cfg_wdata_i[ENABLE_LSB +: NUM_REQ] ;
            next_timeout_en = cfg_wdata_i[TIMEOUT_EN_BIT];
            next_refresh_en = cfg_wdata_i[REFRESH_EN_BIT];
            next_fair_field = cfg_wdata_i[FAIR_MSB:FAIR_LSB];
            next_toggle_en  = cfg_wdata_i[TOGGLE_EN_BIT];
            next_prio       = cfg_wdata_i[PRIO_LSB +: NUM_REQ];
        end
    end

    // grant state machine
    always_comb begin
        next_state      = state;
        next_owner      = owner;
        next_gnt_n      = 9'h1ff;
        next_broken     = broken;
        next_served     = served;
        next_fair_cnt   = fair_cnt;
        next_fair_armed = fair_armed;
        next_idle_cnt   = idle_cnt;
        next_tog_cnt    = tog_cnt;
        next_tog_done   = tog_done;
        // without refresh a broken master that keeps requesting stays
        // broken; once its request drops it is ignored for good
        case (state)
            IDLE: begin
                if (!ext_arb && pick_ok) begin
                    next_state      = WAIT_FRAME;
                    next_owner      = pick;
                    next_gnt_n[pick] = 1'b0;
                    next_fair_cnt   = fair_field;
                    next_fair_armed = 1'b0;
                    next_idle_cnt   = '0;
                    next_tog_cnt    = '0;
                    next_tog_done   = 1'b0;
                end
            end
            WAIT_FRAME: begin
                next_gnt_n[owner] = 1'b0;
                if (!eligible[owner]) begin
                    next_gnt_n = 9'h1ff;
                    next_state = IDLE;
                end else if (!frame_s2) begin
                    next_state      = OWNED;
                    next_fair_armed = 1'b1;
                    next_served[owner] = 1'b1;
                end else if (timeout_en && bus_idle) begin
                    next_idle_cnt = idle_cnt + 5'h01;
                    if (idle_cnt + 5'h01 >= BROKEN_CYCLES) begin
                        next_gnt_n     = 9'h1ff;
                        next_broken[owner] = 1'b1;
                        next_state     = IDLE;
                    end
                end
            end
            OWNED: begin
                next_gnt_n[owner] = 1'b0;
                if (toggle_en && !tog_done) begin
                    if (tog_cnt == TOGGLE_DELAY) begin
                        next_gnt_n[owner] = 1'b1;
                        next_tog_done     = 1'b1;
                    end else begin
                        next_tog_cnt = tog_cnt + 2'h1;
                    end
                end
                if (frame_fall) next_fair_armed = 1'b1;
                if (fair_armed && others_wait && fair_cnt != 8'h00) begin
                    next_fair_cnt = fair_cnt - 8'h01;
                end
                if (!eligible[owner] ||
                    (fair_field != 8'h00 && others_wait && fair_armed &&
                     fair_cnt == 8'h01)) begin
                    next_gnt_n = 9'h1ff;
                    next_state = IDLE;
                end
            end
            default: next_state = IDLE;
        endcase
        // refresh broken state once every non-broken master was served
        if (refresh_en && (broken != 9'h000) &&
            ((next_served | broken) == 9'h1ff)) begin
            // a master timing out in this same cycle stays broken: set wins
            next_broken = next_broken & ~broken;
            next_served = 9'h000;
        end
        if (ext_arb) next_gnt_n = 9'h1ff;
    end

    // all state registers apart from the input synchronisers, including configuration
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            enable      <= ENABLE_RESET;
            prio        <= PRIO_RESET;
            timeout_en  <= 1'b0;
            refresh_en  <= 1'b0;
            fair_field  <= FAIR_RESET;
            toggle_en   <= 1'b0;
            ext_arb     <= 1'b0;
            state       <= IDLE;
            owner       <= 4'h0;
            gnt_n       <= 9'h1ff;
            broken      <= 9'h000;
            served      <= 9'h000;
            fair_cnt    <= FAIR_RESET;
            fair_armed  <= 1'b0;
            idle_cnt    <= 5'h00;
            tog_cnt     <= 2'h0;
            tog_done    <= 1'b0;
            frame_prev  <= 1'b1;
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            enable      <= next_enable;
            prio        <= next_prio;
            timeout_en  <= next_timeout_en;
            refresh_en  <= next_refresh_en;
            fair_field  <= next_fair_field;
            toggle_en   <= next_toggle_en;
            ext_arb     <= next_ext_arb;
            state       <= next_state;
            owner       <= next_owner;
            gnt_n       <= next_gnt_n;
            broken      <= next_broken;
            served      <= next_served;
            fair_cnt    <= next_fair_cnt;
            fair_armed  <= next_fair_armed;
            idle_cnt    <= next_idle_cnt;
            tog_cnt     <= next_tog_cnt;
            tog_done    <= next_tog_done;
            frame_prev  <= frame_s2;
            cfg_rdata_o <= next_rdata;
        end
    end

    assign gnt_n_o  = gnt_n;
    assign broken_o = broken;

    one_grant_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $countones(~gnt_n) <= 1)
        else $error("more than one grant active");
    no_bad_grant_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((~gnt_n) & (~enable | broken)) == 9'h000 || $changed(enable)
        || $changed(broken))
        else $error("grant to disabled or broken master");
    // readback of bit 9 lags the synchronised strap by two edges
    strap_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##2 ($past(cfg_addr_i) != CFG_OFFSET ||
             cfg_rdata_o[STRAP_BIT] == $past(strap_s2, 2)))
        else $error("strap bit does not follow strap");
    timeout_drop_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == WAIT_FRAME && next_state == IDLE && eligible[owner])
        |=> gnt_n == 9'h1ff && broken[$past(owner)])
        else $error("timeout did not drop grant and mark broken");
    timeout_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !timeout_en |=> $stable(broken) || $past(refresh_en))
        else $error("broken set with timeout off");
    fair_reload_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == IDLE && next_state == WAIT_FRAME)
        |=> fair_cnt == $past(fair_field))
        else $error("fairness counter not reloaded");
    fair_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == OWNED && fair_field == 8'h00 && eligible[owner]
         && !toggle_en && !cfg_hit) |=> !gnt_n[$past(owner)])
        else $error("grant removed with fairness zero");
    no_toggle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == OWNED && !toggle_en && eligible[owner]
         && !(fair_armed && others_wait && fair_cnt == 8'h01)
         && !cfg_hit) |=> !gnt_n[$past(owner)])
        else $error("grant dropped with toggle off");
endmodule
`default_nettype wire

// file: tb/pci_master_model.sv
// behavioural external bus masters facing the arbiter
`timescale 1ns/1ps
`default_nettype none
module pci_master_model (
    input  wire logic       clk_i,
    input  wire logic [8:0] want_i,
    input  wire logic [8:0] starts_i,
    input  wire logic [8:0] gnt_n_i,
    output logic      [8:0] req_n_o,
    output logic            frame_n_o,
    output logic            irdy_n_o
);
    logic [3:0] left;
    logic [8:0] done;
    logic [8:0] owner;
    logic [8:0] go;

    // only a master told to start opens a frame; others just sit on the grant
    assign go = ~gnt_n_i & starts_i & want_i & ~done;

    initial begin
        req_n_o = 9'h1ff;
        frame_n_o = 1'b1;
        irdy_n_o = 1'b1;
        left = 4'h0;
        done = 9'h0;
        owner = 9'h0;
    end

    // request is held through the frame so a grant cut is the arbiter's doing;
    // moves on the rising edge so it never races the bench's falling-edge stimulus
    always @(posedge clk_i) begin
        done <= done & want_i;
        if (left != 4'h0) begin
            left <= left - 4'h1;
            if (left == 4'h1) begin
                frame_n_o <= 1'b1;
                irdy_n_o  <= 1'b1;
                done      <= (done | owner) & want_i;
            end
        end else if (frame_n_o && |go) begin
            frame_n_o <= 1'b0;
            irdy_n_o  <= 1'b0;
            left      <= 4'he;
            owner     <= go;
        end
        req_n_o <= ~(want_i & ~done);
    end
endmodule
`default_nettype wire

// file: tb/bus_request_arbiter_tb_top.sv
// self-checking bench for the secondary bus request arbiter
`timescale 1ns/1ps
`default_nettype none
module bus_request_arbiter_tb_top;
    import bus_arbiter_pkg::*;
    logic        clk, resetn, frame_n, irdy_n, strap, wr;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [8:0]  req_n, gnt_n, broken, want, starts;
    int          n_fail, n_tests, n;

    bus_request_arbiter u_bus_request_arbiter (
        .clk_i(clk), .resetn_i(resetn), .req_n_i(req_n),
        .frame_n_i(frame_n), .irdy_n_i(irdy_n),
        .arbiter_select_strap_i(strap), .cfg_wr_i(wr), .cfg_addr_i(addr),
        .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .gnt_n_o(gnt_n),
        .broken_o(broken));
    pci_master_model u_pci_master_model (
        .clk_i(clk), .want_i(want), .starts_i(starts), .gnt_n_i(gnt_n),
        .req_n_o(req_n), .frame_n_o(frame_n), .irdy_n_o(irdy_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [8:0] gp(input int k);
        return ~(9'h1 << k);
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wr48(input logic [31:0] d);
        wr = 1'b1;
        addr = CFG_OFFSET;
        wdata = d;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        addr = a;
        cyc(1);
        chk(rdata, exp);
    endtask
    // bounded waits: a hung arbiter shows up as a failed compare
    task automatic wait_gnt(input int k);
        n = 0;
        while (gnt_n[k] !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(gnt_n, gp(k));
    endtask
    // counts cycles the grant stays low, from the cycle it was first seen
    task automatic held(input int k);
        n = 0;
        while (gnt_n[k] === 1'b0 && n < 60) begin
            cyc(1);
            n++;
        end
    endtask

    // at most one grant at any time
    always @(negedge clk) if (resetn) chk($countones(~gnt_n) <= 1, 1'b1);

    task automatic t_regs();
        chk(gnt_n, 9'h1ff);
        chk(broken, 9'h0);
        rd(CFG_OFFSET, 32'h004081ff);
        wr48(32'hffffffff);
        rd(CFG_OFFSET, 32'h7fdffdff);
        rd(8'h44, 32'h0);
        wr48(32'h004081ff);
        strap = 1'b1;
        cyc(4);
        want = 9'h002;
        cyc(6);
        rd(CFG_OFFSET, 32'h004083ff);
        chk(gnt_n, 9'h1ff);
        want = 9'h0;
        strap = 1'b0;
        cyc(4);
        $display("regs test done");
    endtask
    task automatic t_enable();
        wr48(32'h004081fa);
        want = 9'h005;
        cyc(12);
        chk(gnt_n, 9'h1ff);
        wr48(32'h004081ff);
        wait_gnt(0);
        want = 9'h0;
        cyc(6);
        wr48(32'h010081ff);
        want = 9'h005;
        wait_gnt(2);
        want = 9'h0;
        cyc(6);
        wr48(32'h004081ff);
        $display("enable test done");
    endtask
    // grant sits idle with no frame until the timeout drops it
    task automatic t_timeout();
        wr48(32'h004085ff);
        want = 9'h008;
        wait_gnt(3);
        held(3);
        chk(n, BROKEN_CYCLES);
        chk(broken, 9'h008);
        want = 9'h0;
        cyc(3);
        want = 9'h008;
        cyc(12);
        chk(gnt_n, 9'h1ff);
        wr48(32'h00408dff);
        starts = 9'h1f7;
        want = 9'h1ff;
        n = 0;
        while (broken !== 9'h0 && n < 400) begin
            cyc(1);
            n++;
        end
        chk(broken, 9'h0);
        want = 9'h0;
        starts = 9'h0;
        cyc(30);
        wr48(32'h004081ff);
        $display("timeout test done");
    endtask
    task automatic t_fair(input logic [7:0] f);
        wr48({12'h004, f, 12'h1ff});
        starts = 9'h010;
        want = 9'h010;
        wait_gnt(4);
        want = 9'h050;
        held(4);
        chk(n >= 14, f == 8'h0);
        want = 9'h0;
        cyc(20);
        $display("fairness test done");
    endtask
    task automatic t_toggle(input logic tg);
        wr48({11'h002, tg, 20'h081ff});
        starts = 9'h002;
        want = 9'h002;
        wait_gnt(1);
        n = 0;
        while (frame_n !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        n = 0;
        repeat (10) begin
            cyc(1);
            n += (gnt_n[1] === 1'b1);
        end
        chk(n, tg);
        want = 9'h0;
        cyc(20);
        $display("toggle test done");
    endtask

    task automatic summarize();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 4000);
        n_fail++;
        summarize();
    end
    initial begin
        {n_fail, n_tests, n} = '0;
        {resetn, strap, wr, addr, wdata, want, starts} = '0;
        cyc(6);
        resetn = 1'b1;
        cyc(2);
        t_regs();
        t_enable();
        t_timeout();
        t_fair(8'h00);
        t_fair(8'h04);
        t_toggle(1'b0);
        t_toggle(1'b1);
        summarize();
    end
endmodule
`default_nettype wire
